// >>> rtl/adc_ctl_consts.vh
// register offsets, field positions, reset values and package codes for the converter control block
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH

// register byte offsets
`define TRG_MODE_OFS        8'h00
`define IN_MODE_OFS         8'h04
`define EIRQ_EN_LO_OFS      8'h08
`define EIRQ_EN_HI_OFS      8'h0c
`define EIRQ_STATUS_OFS     8'h10
`define EIRQ_MASK_OFS       8'h14
`define CORE_STATUS_OFS     8'h18

// trigger mode field positions
`define TRG_SYNC_LSB        0
`define TRG_SYNC_W          5
`define TRG_PRESYNC_LSB     8
`define TRG_PRESYNC_W       2
`define TRG_MODE_MASK       32'h0000031f

// input mode register layout
`define IN_MODE_MASK        32'h03ffffff
`define IN_MODE_W           26
`define IN_FIRST            32
`define IN_HI_COUNT         13

// early enable high register layout
`define EIRQ_HI_MASK        32'h00001fff
`define EIRQ_HI_W           13

// reset values
`define TRG_MODE_RST        32'h00000000
`define IN_MODE_RST         32'h00000000
`define EIRQ_EN_RST         32'h00000000

// package options
`define PKG_SMALL           2'h0
`define PKG_MIDDLE          2'h1
`define PKG_LARGE           2'h2

`endif

// >>> rtl/adc_trigger_input_mode_early_irq.v
// converter trigger, input mode and early interrupt control registers on classic wishbone
//
// Functional notes
// - converters 0 and 1 each have a bit that selects presynchronized triggers when set.
// - converters 0 to 4 each have a bit that makes the first sample after idle synchronous when set.
// - inputs 32 to 44 each have a mode bit, set for differential and clear for single-ended.
// - inputs 32 to 44 each have a format bit, set for signed results and clear for unsigned.
// - the input mode register packs mode over format per input, input 44 at 25:24 down to input 32 at 1:0.
// - the low early enable register holds one enable per input 0 to 31 at the bit equal to the input.
// - the high early enable register holds inputs 32 to 44 in bits 12:0, bits 31:13 unimplemented.
// - no early interrupt is raised for an input whose enable bit is clear.
// - bits for inputs 32 to 34 are absent on the small package, those for 35 to 44 on small and middle.
// - unimplemented bits read as zero and ignore writes.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_consts.vh"

module adc_trigger_input_mode_early_irq #(
  parameter [1:0] PKG_OPTION = 2'h2,
  parameter       N_INPUTS   = 45
) (
  // clock and reset
  input  wire                clk_i,
  input  wire                rst_i,
  // wishbone slave
  input  wire                cyc_i,
  input  wire                stb_i,
  input  wire                we_i,
  input  wire [7:0]          adr_i,
  input  wire [3:0]          sel_i,
  input  wire [31:0]         dat_i,
  output reg  [31:0]         dat_o,
  output reg                 ack_o,
  // early event flags from the converter core
  input  wire [N_INPUTS-1:0] early_result_flag_i,
  // controls towards the converter core
  output reg  [1:0]          presync_trigger_sel_o,
  output reg  [4:0]          first_sample_sync_o,
  output reg  [12:0]         pair_mode_o,
  output reg  [12:0]         twos_complement_result_o,
  output reg  [N_INPUTS-1:0] early_irq_req_o,
  // interrupt
  output reg                 irq_o
);

  // ----------------------------------------------------------------
  // package dependent implementation masks
  // ----------------------------------------------------------------

  // enable bits present for inputs 32..44 by package
  function [12:0] hi_present;
    input [1:0] pkg;
    begin
      if (pkg == `PKG_SMALL)
        hi_present = 13'h0000;
      else if (pkg == `PKG_MIDDLE)
        hi_present = 13'h0007;
      else
        hi_present = 13'h1fff;
    end
  endfunction

  // widen each present input into its mode/format pair
  function [25:0] pair_mask;
    input [12:0] present;
    integer k;
    begin
      pair_mask = 26'h0;
      for (k = 0; k < 13; k = k + 1) begin
        pair_mask[2*k]   = present[k];
        pair_mask[2*k+1] = present[k];
      end
    end
  endfunction

  // bus byte lanes to a bit mask
  function [31:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // true when the address lands on one register's word
  // offsets are word aligned, so sub-word addresses decode as unmapped
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  // absent inputs are masked at write time, so reads need no masking of their own
  wire [12:0] hi_mask   = hi_present(PKG_OPTION);
  wire [31:0] imode_msk = {6'h00, pair_mask(hi_mask)} & `IN_MODE_MASK;
  wire [31:0] eihi_msk  = {19'h00000, hi_mask} & `EIRQ_HI_MASK;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------

  // one wait state: ack in the cycle after the request is seen
  wire        req    = cyc_i & stb_i & ~ack_o;
  wire        wr     = req & we_i;
  wire [31:0] lmask  = lane_mask(sel_i);

  // one select per register, shared by write strobes and the status read clear; the read mux decodes adr_i itself
  wire        at_trg    = hit(adr_i, `TRG_MODE_OFS);
  wire        at_imode  = hit(adr_i, `IN_MODE_OFS);
  wire        at_eilo   = hit(adr_i, `EIRQ_EN_LO_OFS);
  wire        at_eihi   = hit(adr_i, `EIRQ_EN_HI_OFS);
  wire        at_emask  = hit(adr_i, `EIRQ_MASK_OFS);
  wire        at_status = hit(adr_i, `EIRQ_STATUS_OFS);

  // write strobes; a strobe held past ack would start a second transfer
  wire        wr_trg    = wr & at_trg;
  wire        wr_imode  = wr & at_imode;
  wire        wr_eilo   = wr & at_eilo;
  wire        wr_eihi   = wr & at_eihi;
  wire        wr_emask  = wr & at_emask;

  // keep untouched lanes at their current value
  wire [31:0] trg_q;
  wire [31:0] imode_q;
  wire [31:0] eilo_q;
  wire [31:0] eihi_q;
  wire [31:0] emask_q;
  reg  [31:0] status;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] lm;
    begin
      merge = (old & ~lm) | (nw & lm);
    end
  endfunction

  // next word per register: untouched byte lanes keep their current value
  wire [31:0] next_trg   = merge(trg_q, dat_i, lmask);
  wire [31:0] next_imode = merge(imode_q, dat_i, lmask);
  wire [31:0] next_eilo  = merge(eilo_q, dat_i, lmask);
  wire [31:0] next_eihi  = merge(eihi_q, dat_i, lmask);
  wire [31:0] next_emask = merge(emask_q, dat_i, lmask);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------

  // trigger mode: presync at 9:8, synchronous first sample at 4:0
  ctl_reg_store #(.WIDTH(32)) u_trg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_trg),
    .wmask_i (`TRG_MODE_MASK),
    .wdata_i (next_trg),
    .q_o     (trg_q)
  );

  // input mode pairs, mode above format
  // a write to an absent pair is dropped by the mask, not by the decode
  ctl_reg_store #(.WIDTH(32)) u_imode (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_imode),
    .wmask_i (imode_msk),
    .wdata_i (next_imode),
    .q_o     (imode_q)
  );

  // early enables for inputs 0..31 at bit equal to input
  // every package keeps these inputs, so no package mask applies here
  ctl_reg_store #(.WIDTH(32)) u_eilo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_eilo),
    .wmask_i (32'hffffffff),
    .wdata_i (next_eilo),
    .q_o     (eilo_q)
  );

  // early enables for inputs 32..44 at 12:0
  ctl_reg_store #(.WIDTH(32)) u_eihi (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_eihi),
    .wmask_i (eihi_msk),
    .wdata_i (next_eihi),
    .q_o     (eihi_q)
  );

  // interrupt mask, same layout as status
  // bits beyond the two status events are stored but have no effect
  ctl_reg_store #(.WIDTH(32)) u_emask (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_emask),
    .wmask_i (32'hffffffff),
    .wdata_i (next_emask),
    .q_o     (emask_q)
  );

  // ----------------------------------------------------------------
  // early requests and sticky status
  // ----------------------------------------------------------------

  // combined enable vector over all inputs
  wire [63:0]         en_all   = {19'h00000, eihi_q[12:0], eilo_q};
  wire [N_INPUTS-1:0] next_req = early_result_flag_i & en_all[N_INPUTS-1:0];

  // status bit 0: any early request, bit 1: a write landed on the trigger register
  // trigger writes are reported too, so software can see a reconfiguration land
  wire       rd_status = req & ~we_i & at_status;
  wire [1:0] events    = {wr_trg, |next_req};

  // a read clears, but an event in the same cycle wins so none is lost
  // limitation: bit 0 follows the request level and re-arms while a flag and its enable stay high
  wire [1:0] next_status = (rd_status ? 2'b00 : status[1:0]) | events;
  wire       next_irq    = |(status & emask_q);

  // sticky status register
  always @(posedge clk_i) begin
    if (rst_i) begin
      status <= 32'h00000000;
    end else begin
      status <= {30'h0, next_status};
    end
  end

  // ----------------------------------------------------------------
  // core controls
  // ----------------------------------------------------------------

  // trigger register fields towards the converters
  wire [1:0]  next_presync    = trg_q[`TRG_PRESYNC_LSB+:`TRG_PRESYNC_W];
  wire [4:0]  next_first_sync = trg_q[`TRG_SYNC_LSB+:`TRG_SYNC_W];

  // mode sits above format in each pair; bit k of the outputs is input 32+k
  // one assign per bit keeps a single driver on every output bit
  wire [12:0] next_pair_mode;
  wire [12:0] next_twos_fmt;
  genvar g;
  generate
    for (g = 0; g < `IN_HI_COUNT; g = g + 1) begin : g_unpack
      assign next_pair_mode[g] = imode_q[2*g+1];
      assign next_twos_fmt[g]  = imode_q[2*g];
    end
  endgenerate

  // outputs to the core, all from flip-flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      presync_trigger_sel_o    <= 2'h0;
      first_sample_sync_o      <= 5'h00;
      pair_mode_o              <= 13'h0000;
      twos_complement_result_o <= 13'h0000;
      early_irq_req_o          <= {N_INPUTS{1'b0}};
      irq_o                    <= 1'b0;
    end else begin
      presync_trigger_sel_o    <= next_presync;
      first_sample_sync_o      <= next_first_sync;
      early_irq_req_o          <= next_req;
      irq_o                    <= next_irq;
      pair_mode_o              <= next_pair_mode;
      twos_complement_result_o <= next_twos_fmt;
    end
  end

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------

  // unmapped addresses read zero and ignore writes
  // core status mirrors the interrupt line after the mask, so software can poll it
  reg [31:0] rd_mux;
  always @* begin
    case (adr_i)
      `TRG_MODE_OFS:    rd_mux = trg_q;
      `IN_MODE_OFS:     rd_mux = imode_q;
      `EIRQ_EN_LO_OFS:  rd_mux = eilo_q;
      `EIRQ_EN_HI_OFS:  rd_mux = eihi_q;
      `EIRQ_STATUS_OFS: rd_mux = status;
      `EIRQ_MASK_OFS:   rd_mux = emask_q;
      `CORE_STATUS_OFS: rd_mux = {31'h0, irq_o};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // read data stands only in the ack cycle; zero otherwise keeps the bus quiet
  wire [31:0] next_rdata = req ? rd_mux : 32'h00000000;
  wire        next_ack   = req;                        // one wait state, never back to back

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_rdata;
    end
  end

endmodule // adc_trigger_input_mode_early_irq

`default_nettype wire

// >>> rtl/ctl_reg_store.v
// word register with write mask and registered read data
`timescale 1ns/100ps
`default_nettype none

module ctl_reg_store #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // write side
  input  wire             wr_i,
  input  wire [WIDTH-1:0] wmask_i,
  input  wire [WIDTH-1:0] wdata_i,
  // read side
  output reg  [WIDTH-1:0] q_o
);

  // unimplemented bits are held at zero through the mask
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= {WIDTH{1'b0}};
    end else if (wr_i) begin
      q_o <= wdata_i & wmask_i;
    end
  end

endmodule // ctl_reg_store

`default_nettype wire

// >>> tb/adc_ctl_asserts.sv
// port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_consts.vh"
module adc_ctl_asserts #(
  parameter N_INPUTS = 45
) (
  // clock, reset and bus
  input wire logic                clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [7:0]          adr_i,
  input wire logic [31:0]         dat_o,
  // controls and early requests
  input wire logic [1:0]          presync_trigger_sel_o,
  input wire logic [N_INPUTS-1:0] early_result_flag_i, early_irq_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // read and trigger-write qualifiers
  wire logic rd = ack_o && !we_i;
  wire logic wr_trg = ack_o && we_i && adr_i == `TRG_MODE_OFS;
  // ----
  // bus handshake
  // ----
  a_ack_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack not one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_idle_data: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  // ----
  // register contents
  // ----
  a_trg_unused: assert property (rd && adr_i == `TRG_MODE_OFS |-> (dat_o & ~`TRG_MODE_MASK) == 32'h0)
    else $error("trigger unused bits set");
  a_in_unused: assert property (rd && adr_i == `IN_MODE_OFS |-> dat_o[31:26] == 6'h0)
    else $error("input mode unused bits set");
  a_hi_unused: assert property (rd && adr_i == `EIRQ_EN_HI_OFS |-> dat_o[31:13] == 19'h0)
    else $error("high enable unused bits set");
  // the select may only move after a trigger write, allowing one cycle of lag
  a_presync_cause: assert property ($changed(presync_trigger_sel_o) |-> $past(wr_trg) || $past(wr_trg, 2))
    else $error("presync select moved without write");
  // ----
  // early requests
  // ----
  a_req_gated: assert property ((early_irq_req_o & ~$past(early_result_flag_i)) == '0)
    else $error("early request without flag");
  a_req_reset: assert property ($fell(rst_i) |-> early_irq_req_o == '0)
    else $error("early request after reset");
  // main scenarios
  c_trg_write: cover property (wr_trg);
  c_in_read: cover property (rd && adr_i == `IN_MODE_OFS);
  c_req: cover property (|early_irq_req_o);
endmodule // adc_ctl_asserts
bind adc_trigger_input_mode_early_irq adc_ctl_asserts #(.N_INPUTS(N_INPUTS)) chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .dat_o(dat_o),
  .presync_trigger_sel_o(presync_trigger_sel_o), .early_result_flag_i(early_result_flag_i),
  .early_irq_req_o(early_irq_req_o));
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_consts.vh"
module tb_top;
  // ----
  // signals
  // ----
  logic             clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]       adr_i = 8'h00;
  logic [3:0]       sel_i = 4'h0;
  logic [31:0]      dat_i = 32'h0;
  logic [44:0]      flag  = 45'h0;
  wire logic [31:0] dat_o;
  wire logic        ack_o, irq_o;
  wire logic [1:0]  psel;
  wire logic [4:0]  ssync;
  wire logic [12:0] pmode, tfmt, pmode2, pmode3;
  wire logic [44:0] req, req2, req3;
  int               err_count = 0;
  int               comparisons = 0;
  // 25 MHz clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // full package device
  adc_trigger_input_mode_early_irq uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .early_result_flag_i(flag),
    .presync_trigger_sel_o(psel), .first_sample_sync_o(ssync), .pair_mode_o(pmode),
    .twos_complement_result_o(tfmt), .early_irq_req_o(req), .irq_o(irq_o));
  // smallest package on the same bus, so absent bits can be seen staying clear
  adc_trigger_input_mode_early_irq #(.PKG_OPTION(`PKG_SMALL)) uut2 (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(), .ack_o(),
    .early_result_flag_i(flag), .presync_trigger_sel_o(), .first_sample_sync_o(), .pair_mode_o(pmode2),
    .twos_complement_result_o(), .early_irq_req_o(req2), .irq_o());
  // middle package: only inputs 32 to 34 keep their bits
  adc_trigger_input_mode_early_irq #(.PKG_OPTION(`PKG_MIDDLE)) uut3 (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(), .ack_o(),
    .early_result_flag_i(flag), .presync_trigger_sel_o(), .first_sample_sync_o(), .pair_mode_o(pmode3),
    .twos_complement_result_o(), .early_irq_req_o(req3), .irq_o());
  // ----
  // tasks
  // ----
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle, entered just after an edge; returns one edge after release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      err_count++;
      conclude();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask
  // registered outputs lag a write or a flag by a few cycles
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("trg", `TRG_MODE_OFS, 32'h0);
    rd("inm", `IN_MODE_OFS, 32'h0);
    rd("enl", `EIRQ_EN_LO_OFS, 32'h0);
    rd("enh", `EIRQ_EN_HI_OFS, 32'h0);
    $display("test reset done");
    wr(`TRG_MODE_OFS, 32'hffffffff, 4'hf);
    rd("trg", `TRG_MODE_OFS, 32'h0000031f);
    wr(`TRG_MODE_OFS, 32'h00000102, 4'hf);
    settle();
    chk("psel", 2'h1, psel);
    chk("ssync", 5'h02, ssync);
    $display("test trigger done");
    wr(`IN_MODE_OFS, 32'hffffffff, 4'hf);
    rd("inm", `IN_MODE_OFS, 32'h03ffffff);
    settle();
    chk("pmode2", 13'h0, pmode2);
    chk("pmode3", 13'h0007, pmode3);
    wr(`IN_MODE_OFS, 32'h02400001, 4'hf);
    // only the low lane may change
    wr(`IN_MODE_OFS, 32'hffffffaa, 4'h1);
    rd("inm", `IN_MODE_OFS, 32'h024000aa);
    settle();
    chk("pmode", 13'h100f, pmode);
    chk("tfmt", 13'h0800, tfmt);
    $display("test input mode done");
    wr(`EIRQ_EN_LO_OFS, 32'h80000001, 4'hf);
    wr(`EIRQ_EN_HI_OFS, 32'hffffffff, 4'hf);
    rd("enh", `EIRQ_EN_HI_OFS, 32'h00001fff);
    flag <= {45{1'b1}};
    settle();
    chk("req", {13'h1fff, 32'h80000001}, req);
    chk("req2", {13'h0, 32'h80000001}, req2);
    chk("req3", {13'h0007, 32'h80000001}, req3);
    chk("irq masked", 1'b0, irq_o);
    wr(`EIRQ_EN_LO_OFS, 32'h0, 4'hf);
    settle();
    chk("req", {13'h1fff, 32'h0}, req);
    flag <= 45'h0;
    wr(`EIRQ_MASK_OFS, 32'h1, 4'hf);
    settle();
    chk("irq", 1'b1, irq_o);
    rd("core", `CORE_STATUS_OFS, 32'h1);
    rd("status", `EIRQ_STATUS_OFS, 32'h3);
    settle();
    chk("irq cleared", 1'b0, irq_o);
    $display("test early irq done");
    // unmapped place answers zero and keeps nothing
    wr(8'h20, 32'hffffffff, 4'hf);
    rd("unmapped", 8'h20, 32'h0);
    rd("trg", `TRG_MODE_OFS, 32'h00000102);
    $display("test unmapped done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
